// ### inc/hims_pkg.sv
// ****************************************************************
// Host interface mode select package
// ****************************************************************
package hims_pkg;

  // Parallel data word width
  localparam int HIMS_DATA_W = 12;
  // Shared pin positions in the parallel word
  localparam int HIMS_BIT_NINE = 9;
  localparam int HIMS_BIT_TEN = 10;
  localparam int HIMS_BIT_ELEVEN = 11;
  // Serial shift register width
  localparam int HIMS_SHIFT_W = 24;
  // Highest serial clock rate in MHz
  localparam int HIMS_SCLK_MAX_MHZ = 50;
  // I2C bus rates in kHz
  localparam int HIMS_I2C_STD_KHZ = 100;
  localparam int HIMS_I2C_FAST_KHZ = 400;
  // Pull-down value in kilo-ohms used in power-down
  localparam int HIMS_PULL_KOHM = 100;
  // Reset value of the queue decision
  localparam logic HIMS_QUEUE_RST = 1'b0;

  // Interface mode
  typedef enum logic [1:0] {
    HIMS_MODE_PAR = 2'b00,
    HIMS_MODE_SPI = 2'b01,
    HIMS_MODE_I2C = 2'b10
  } hims_mode_t;

  // Power-down output state
  typedef enum logic [1:0] {
    HIMS_OUT_ACTIVE = 2'b00,
    HIMS_OUT_HIZ = 2'b01,
    HIMS_OUT_PULL = 2'b10
  } hims_out_t;

  // Serial link pins as seen by the link domain
  typedef struct packed {
    logic spi_clk;
    logic spi_din;
    logic scl;
    logic sda_in;
  } hims_ser_t;

endpackage

// ### verilog/hims_top.sv
`timescale 1ns/100ps
`default_nettype none

module hims_top
  import hims_pkg::*;
#(
  parameter int SHIFT_W = HIMS_SHIFT_W
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_clear_n,
  input wire logic i_power_down_pin,
  input wire logic i_pd_pull_sel,
  input wire logic i_queue_enable_strap,
  input wire logic i_serial_parallel_select,
  input wire logic [HIMS_DATA_W-1:0] i_par_data,
  input wire logic i_data_pin_twelve,
  input wire logic i_data_pin_eleven,
  input wire logic [SHIFT_W-1:0] i_readback_word,
  output logic o_data_pin_eleven_oe,
  output logic o_data_pin_eleven,
  output logic [1:0] o_mode,
  output logic [HIMS_DATA_W-1:0] o_par_data,
  output logic o_queue_enable,
  output logic o_power_down,
  output logic [1:0] o_out_state,
  output logic o_serial_readback_output,
  output logic o_serial_readback_output_oe,
  output logic [SHIFT_W-1:0] o_spi_word,
  output logic o_spi_word_toggle,
  output logic o_i2c_start_toggle,
  output logic o_i2c_sda_low,
  output logic o_link_clk
);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************

  // First and second stages for the static pins
  logic [3:0] pin_meta;
  logic [3:0] pin_sync;
  // Parallel word stages
  logic [HIMS_DATA_W-1:0] par_meta;
  logic [HIMS_DATA_W-1:0] par_sync;
  // Clear input stages and edge history
  logic clr_meta;
  logic clr_sync;
  logic clr_prev;

  // Two flops on each static pin input except the pull select, which is used unsynchronised
  // They run through reset on purpose: the queue strap is caught at the
  // first edge after release, so its synchronised value must already
  // stand then instead of a reset zero
  always_ff @(posedge i_sys_clk) begin
    pin_meta <= {i_power_down_pin, i_serial_parallel_select,
                 i_par_data[HIMS_BIT_NINE], i_queue_enable_strap};
    pin_sync <= pin_meta;
    par_meta <= i_par_data;
    par_sync <= par_meta;
  end

  // Clear input stages and edge history, idle high out of reset
  // Idle high avoids a false falling edge right after release
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      clr_meta <= 1'b1;
      clr_sync <= 1'b1;
      clr_prev <= 1'b1;
    end else begin
      clr_meta <= i_clear_n;
      clr_sync <= clr_meta;
      clr_prev <= clr_sync;
    end
  end

  // Named views of synchronised pins
  logic pd_s;
  logic sel_s;
  logic proto_s;
  logic strap_s;
  logic clr_fall;
  assign pd_s = pin_sync[3];
  assign sel_s = pin_sync[2];
  assign proto_s = pin_sync[1];
  assign strap_s = pin_sync[0];
  assign clr_fall = clr_prev & ~clr_sync;

  // ****************************************************************
  // Mode decode
  // ****************************************************************

  // Mode from the two straps
  function automatic hims_mode_t mode_of(input logic sel, input logic proto);
    if (!sel) begin
      mode_of = HIMS_MODE_PAR;
    end else if (!proto) begin
      mode_of = HIMS_MODE_SPI;
    end else begin
      mode_of = HIMS_MODE_I2C;
    end
  endfunction

  hims_mode_t mode;

  // Mode register, straps assumed static
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      mode <= HIMS_MODE_PAR;
    end else begin
      mode <= mode_of(sel_s, proto_s);
    end
  end
  assign o_mode = mode;

  // Parallel word passes through only in parallel mode
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_par_data <= 12'h000;
    end else if (mode == HIMS_MODE_PAR) begin
      o_par_data <= par_sync;
    end else begin
      o_par_data <= 12'h000;
    end
  end

  // ****************************************************************
  // Write queue strap
  // ****************************************************************

  // Strap caught one cycle after reset release or on clear
  logic strap_armed;
  logic queue_strap;
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      strap_armed <= 1'b1;
      queue_strap <= HIMS_QUEUE_RST;
    end else begin
      strap_armed <= 1'b0;
      if (strap_armed || clr_fall) begin
        queue_strap <= strap_s;
      end
    end
  end

  // Queue usable only in parallel mode
  assign o_queue_enable = queue_strap & (mode == HIMS_MODE_PAR);

  // ****************************************************************
  // Power-down
  // ****************************************************************

  // Level sensitive power-down and output state
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_power_down <= 1'b0;
      o_out_state <= HIMS_OUT_ACTIVE;
    end else begin
      o_power_down <= pd_s;
      if (!pd_s) begin
        o_out_state <= HIMS_OUT_ACTIVE;
      end else if (i_pd_pull_sel) begin
        o_out_state <= HIMS_OUT_PULL;
      end else begin
        o_out_state <= HIMS_OUT_HIZ;
      end
    end
  end

  // ****************************************************************
  // SPI link domain on pin twelve
  // ****************************************************************

  // Pin twelve is the link clock in serial modes
  assign o_link_clk = i_data_pin_twelve;

  // Link-side mode synchronised into the link domain
  logic [1:0] lmode_meta;
  logic [1:0] lmode;
  always_ff @(negedge i_data_pin_twelve) begin
    lmode_meta <= mode;
    lmode <= lmode_meta;
  end

  // Shift register, counter and completed word; no power-down gating
  logic [SHIFT_W-1:0] spi_shift;
  logic [$clog2(SHIFT_W)-1:0] spi_cnt;
  logic [SHIFT_W-1:0] spi_word;
  // Link domain has no reset as its clock stops; the toggle needs a known
  // start so that the system side sees no false word
  logic spi_tog = 1'b0;
  always_ff @(negedge i_data_pin_twelve) begin
    if (lmode == HIMS_MODE_SPI) begin
      spi_shift <= {spi_shift[SHIFT_W-2:0], i_data_pin_eleven};
      if (spi_cnt == SHIFT_W[$clog2(SHIFT_W)-1:0] - 1'b1) begin
        spi_cnt <= '0;
        spi_word <= {spi_shift[SHIFT_W-2:0], i_data_pin_eleven};
        spi_tog <= ~spi_tog;
      end else begin
        spi_cnt <= spi_cnt + 1'b1;
      end
    end else begin
      spi_cnt <= '0;
    end
  end

  // Readback shifts out on rising clock edge
  // Bit index follows the count of falling edges already taken
  logic rb_bit;
  always_ff @(posedge i_data_pin_twelve) begin
    rb_bit <= i_readback_word[SHIFT_W-1-int'(spi_cnt)];
  end
  assign o_serial_readback_output = rb_bit;
  assign o_serial_readback_output_oe = (mode == HIMS_MODE_SPI);

  // Word toggle crosses back to system clock
  logic [2:0] tog_sync;
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      tog_sync <= 3'h0;
      o_spi_word <= '0;
    end else begin
      tog_sync <= {tog_sync[1:0], spi_tog};
      if (tog_sync[2] != tog_sync[1]) begin
        o_spi_word <= spi_word;
      end
    end
  end
  assign o_spi_word_toggle = tog_sync[2];

  // ****************************************************************
  // I2C pin handling
  // ****************************************************************

  // SDA and SCL sampled on system clock, rates well below 100 MHz
  logic [1:0] scl_ff;
  logic [1:0] sda_ff;
  logic sda_prev;
  logic start_tog;
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      scl_ff <= 2'h3;
      sda_ff <= 2'h3;
      sda_prev <= 1'b1;
      start_tog <= 1'b0;
    end else begin
      scl_ff <= {scl_ff[0], i_data_pin_twelve};
      sda_ff <= {sda_ff[0], i_data_pin_eleven};
      sda_prev <= sda_ff[1];
      // Start condition at either bus rate
      if (mode == HIMS_MODE_I2C && scl_ff[1] && sda_prev && !sda_ff[1]) begin
        start_tog <= ~start_tog;
      end
    end
  end
  assign o_i2c_start_toggle = start_tog;

  // Open drain: output is always low, enable pulls it
  // Pull request, held low in and out of reset; nothing in the block raises it
  logic i2c_pull;
  assign i2c_pull = o_i2c_sda_low;
  assign o_data_pin_eleven = 1'b0;
  assign o_data_pin_eleven_oe = (mode == HIMS_MODE_I2C) & i2c_pull;
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_i2c_sda_low <= 1'b0;
    end else begin
      o_i2c_sda_low <= 1'b0;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************

  mode_par_data_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    mode != HIMS_MODE_PAR |=> o_par_data == 12'h000) else $error("par data leak");
  queue_serial_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    mode != HIMS_MODE_PAR |-> !o_queue_enable) else $error("queue in serial");
  pd_follow_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    pd_s |=> o_power_down && o_out_state != HIMS_OUT_ACTIVE) else $error("pd lost");
  queue_hold_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    !strap_armed && !clr_fall |=> $stable(queue_strap)) else $error("queue moved");
  spi_mode_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    sel_s && !proto_s |=> mode == HIMS_MODE_SPI) else $error("spi mode");
  i2c_mode_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    sel_s && proto_s |=> mode == HIMS_MODE_I2C) else $error("i2c mode");
  sda_od_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    o_data_pin_eleven_oe |-> mode == HIMS_MODE_I2C && !o_data_pin_eleven)
    else $error("sda drive");
  pd_out_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    !pd_s |=> o_out_state == HIMS_OUT_ACTIVE) else $error("pd stuck");

  // Power-down pin seen high on two samples in a row
  sequence pd_held_s;
    pd_s ##1 pd_s;
  endsequence

  // Staying in power-down keeps the low-power flag up
  pd_hold_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    pd_held_s |=> o_power_down) else $error("pd hold");

  // Readback output is enabled only in SPI mode
  rb_oe_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    o_serial_readback_output_oe |-> mode == HIMS_MODE_SPI) else $error("rb oe");

  // Word toggle change seen by the synchroniser reaches the output
  word_cross_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    tog_sync[2] != tog_sync[1] |=> o_spi_word_toggle != $past(o_spi_word_toggle))
    else $error("word lost");

  // Queue decision follows the strap at a clear edge
  queue_clear_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    clr_fall |=> queue_strap == $past(strap_s)) else $error("queue clear");

endmodule

`default_nettype wire

// ### sim/hims_host_model.sv
`timescale 1ns/100ps
`default_nettype none

// ****************************************************************
// Host side of the serial link: drives pin twelve and pin eleven
// ****************************************************************
module hims_host_model #(
  parameter int W = 8
) (
  output logic o_clk,
  output logic o_dat
);
  // Clock stands high between frames; data starts released high, each word leaves it at its last bit inverted
  initial begin
    o_clk = 1'b1;
    o_dat = 1'b1;
  end

  // Bare clock pulses with data held, used to flush the mode crossing
  task automatic clocks(input int n, input int half);
    repeat (n) begin
      #(half) o_clk = 1'b0;
      #(half) o_clk = 1'b1;
    end
  endtask

  // One word MSB first, data moved just after each rising edge
  task automatic send(input logic [W-1:0] w);
    for (int i = W - 1; i >= 0; i--) begin
      o_dat = w[i];
      #3 o_clk = 1'b0;
      #3 o_clk = 1'b1;
    end
    #1 o_dat = ~o_dat;
  endtask

  // Start condition at a fast-mode pace: data falls while clock high
  task automatic start_cond;
    o_dat = 1'b1;
    #1250 o_dat = 1'b0;
    #1250 o_clk = 1'b0;
    #1250 o_dat = 1'b1;
    #1250 o_clk = 1'b1;
  endtask
endmodule

`default_nettype wire

// ### sim/tb_top.sv
`timescale 1ns/100ps
`default_nettype none

// ****************************************************************
// Testbench for the host interface mode select block
// ****************************************************************
module tb_top
  import hims_pkg::*;
;
  localparam int W = 8; // Short serial word
  logic i_sys_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic clr_n = 1'b1;
  logic pd = 1'b0;
  logic pull = 1'b0;
  logic strap = 1'b1;
  logic sel = 1'b0;
  logic [HIMS_DATA_W-1:0] par = '0;
  logic [W-1:0] rb = '0;
  logic [W-1:0] w;
  logic m_clk, m_dat, oe, d11o, rbo, rboe, tog, itog, t0, sdal, lclk, qen, pdo;
  logic prev = 1'b0;
  logic rb_chk = 1'b0; // Readback checking armed
  int fcnt = 0; // Falling edges in the current frame
  logic [1:0] mode, ost;
  logic [HIMS_DATA_W-1:0] pdat;
  logic [W-1:0] word;
  int failures = 0;
  int n_compared = 0;
  logic [W-1:0] exp_q[$]; // Expected serial words
  wire d11 = m_dat & ~oe; // Open-drain data line with pull-up

  always #5 i_sys_clk = ~i_sys_clk;

  hims_host_model #(.W(W)) m (.o_clk(m_clk), .o_dat(m_dat));

  hims_top #(.SHIFT_W(W)) dut (
    .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_clear_n(clr_n),
    .i_power_down_pin(pd), .i_pd_pull_sel(pull), .i_queue_enable_strap(strap),
    .i_serial_parallel_select(sel), .i_par_data(par), .i_data_pin_twelve(m_clk),
    .i_data_pin_eleven(d11), .i_readback_word(rb), .o_data_pin_eleven_oe(oe),
    .o_data_pin_eleven(d11o), .o_mode(mode), .o_par_data(pdat), .o_queue_enable(qen),
    .o_power_down(pdo), .o_out_state(ost), .o_serial_readback_output(rbo),
    .o_serial_readback_output_oe(rboe), .o_spi_word(word), .o_spi_word_toggle(tog),
    .o_i2c_start_toggle(itog), .o_i2c_sda_low(sdal), .o_link_clk(lclk));

  // ****************************************************************
  // Compare, wait and closing tasks
  // ****************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(negedge i_sys_clk);
  endtask

  task automatic test_done;
    $display("compared=%0d failures=%0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // Watcher: each new serial word is matched against the oldest note
  always @(posedge i_sys_clk) begin
    prev <= tog;
    if (i_rst_n && tog !== prev) chk(word, exp_q.size() ? exp_q.pop_front() : ~word);
  end

  // Readback bit, shifted out on a rising edge, checked at the next falling edge
  always @(negedge m_clk) begin
    if (rb_chk) begin
      fcnt = fcnt + 1;
      if (fcnt > 1) chk(rbo, rb[W-fcnt]);
      if (fcnt == W) fcnt = 0;
    end
  end

  // Watchdog against a hung run
  initial begin
    #300000;
    failures++;
    test_done;
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    void'($urandom(32'hECBA));
    wt(20);
    i_rst_n = 1'b1;
    wt(5);
    chk(mode, HIMS_MODE_PAR);
    chk(qen, 1'b1);
    repeat (4) begin
      par = HIMS_DATA_W'($urandom);
      wt(5);
      chk(pdat, par);
    end
    strap = 1'b0;
    wt(5);
    chk(qen, 1'b1);
    clr_n = 1'b0;
    wt(2);
    clr_n = 1'b1;
    wt(6);
    chk(qen, 1'b0);
    for (int i = 0; i < 2; i++) begin
      pd = 1'b1;
      pull = i[0];
      wt(5);
      chk(pdo, 1'b1);
      chk(ost, i ? HIMS_OUT_PULL : HIMS_OUT_HIZ);
    end
    pd = 1'b0;
    wt(5);
    chk(ost, HIMS_OUT_ACTIVE);
    strap = 1'b1;
    clr_n = 1'b0;
    wt(2);
    clr_n = 1'b1;
    wt(6);
    chk(qen, 1'b1);
    // Straps change only between transfers, queue strap low for serial
    strap = 1'b0;
    sel = 1'b1;
    par = '0;
    pd = 1'b1;
    wt(5);
    chk(mode, HIMS_MODE_SPI);
    chk(qen, 1'b0);
    chk(pdat, '0);
    chk(rboe, 1'b1);
    m.clocks(2, 3);
    rb_chk = 1'b1;
    repeat (3) begin
      w = W'($urandom);
      rb = W'($urandom);
      exp_q.push_back(w);
      m.send(w);
      wt(8);
    end
    rb_chk = 1'b0;
    chk(exp_q.size(), 0);
    par[HIMS_BIT_NINE] = 1'b1;
    wt(5);
    chk(mode, HIMS_MODE_I2C);
    m.clocks(2, 1250);
    t0 = itog;
    m.start_cond;
    wt(5);
    chk(itog, !t0);
    chk(d11o, 1'b0);
    chk(sdal, 1'b0);
    chk(lclk, m_clk);
    test_done;
  end
endmodule

`default_nettype wire
